// ### cmpp_policy.sv
// control mode page policy engine with an apb register file
// assumes a same-clock command core feeding events and commands
//
// Behaviour
// - queue policy selects blocked task handling
// - policy 00 holds all queues during allegiance
// - policy 01 aborts all, others get attention
// - policy 11 aborts only failing initiator tasks
// - owner one keeps application tag unmodified
// - owner zero may modify, ignore tag
// - skip bit disables check on zero protect
// - page enable path sources expected tag
// - clear reject bit accepts unprotected writes
// - reject bit fails unprotected writes when formatted
// - report bit returns page, types 110b
// - report bit change raises unit attention
// - busy timeout field is ignored
// - self test time saturates at ffff
// - external timestamp change reads zero
// - standard timestamp precedence reads one
// - implicit access transitions read zero, disabled
// - initial command priority reads zero
// - zero sense limit means the supported maximum applies
// - sense length is lesser of limits
`timescale 1ns/10ps
`default_nettype none
`include "cmpp_defs.svh"
module cmpp_policy #(
    parameter int NUM_INIT = 16,
    parameter logic [7:0] SENSE_SUPPORTED = 8'hfc
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // command core
    input wire cmpp_pkg::cmpp_event_s event_i,
    input wire cmpp_pkg::cmpp_cmd_s cmd_i,
    input wire logic [NUM_INIT-1:0] queued_i,
    input wire logic formatted_prot_i,
    input wire logic app_tag_check_support_i,
    input wire logic [31:0] selftest_seconds_i,
    input wire logic [7:0] sense_len_i,
    // policy outputs
    output logic hold_all_o,
    output logic [NUM_INIT-1:0] abort_mask_o,
    output logic [NUM_INIT-1:0] ua_cleared_o,
    output logic ua_blr_o,
    output logic cmd_reject_o,
    output logic cmd_accept_o,
    output logic check_skip_o,
    output logic tag_preserve_o,
    output logic tag_ignore_o,
    output logic tag_from_page_o,
    output logic blr_page_o,
    output logic [2:0] protection_types_field_o,
    output logic [15:0] selftest_time_o,
    output logic [7:0] sense_len_o
);
    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [6:0] ctrl_r;
    logic [7:0] max_sense_r;
    logic [3:0] evt_r;
    cmpp_pkg::cmpp_state_e state_r;
    logic [3:0] allegiance_init_r;
    logic [1:0] queue_error_policy;
    logic app_tag_owner;
    logic app_tag_page_enable;
    logic reject_unprotected_writes;
    logic block_length_report_enable;
    logic zero_protect_check_skip;
    logic wr_en;
    logic [31:0] rd_nxt;
    logic [7:0] sense_cap;
    logic [15:0] st_nxt;
    logic [NUM_INIT-1:0] own_bit;
    logic blr_change;
    logic invalid_policy;
    logic prot_checked;

    assign queue_error_policy = ctrl_r[`CMPP_QEP_LSB +: 2];
    assign app_tag_owner = ctrl_r[`CMPP_OWNER_BIT];
    assign app_tag_page_enable = ctrl_r[`CMPP_PAGE_EN_BIT];
    assign reject_unprotected_writes = ctrl_r[`CMPP_RUW_BIT];
    assign block_length_report_enable = ctrl_r[`CMPP_BLR_BIT];
    assign zero_protect_check_skip = ctrl_r[`CMPP_ZPCS_BIT];
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign own_bit = NUM_INIT'(1) << event_i.initiator;
    assign invalid_policy = (queue_error_policy == `CMPP_QEP_RSVD);
    assign blr_change = wr_en && (paddr_i == `CMPP_OFF_CTRL)
        && (pwdata_i[`CMPP_BLR_BIT] != block_length_report_enable);

    // ---------------------------------------------------------------
    // apb slave: zero wait states on reads and writes alike
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= psel_i && !pready_o;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_r <= `CMPP_CTRL_RST;
            max_sense_r <= `CMPP_EXT_RST;
        end else if (wr_en && pready_o) begin
            // busy timeout bits are dropped on purpose
            case (paddr_i)
                `CMPP_OFF_CTRL: begin
                    ctrl_r <= pwdata_i[6:0];
                end
                `CMPP_OFF_SENSE: begin
                    max_sense_r <= pwdata_i[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rd_nxt = 32'h00000000;
        case (paddr_i)
            `CMPP_OFF_CTRL: rd_nxt = {25'h0000000, ctrl_r};
            // ext byte4: external change 0, precedence 1, implicit 0
            `CMPP_OFF_EXT: rd_nxt = {20'h00000, `CMPP_PRIO_NONE,
                8'h02};
            `CMPP_OFF_SENSE: rd_nxt = {24'h000000, max_sense_r};
            `CMPP_OFF_EVENT: rd_nxt = {28'h0000000, evt_r};
            `CMPP_OFF_STATUS: rd_nxt = {25'h0000000, invalid_policy,
                allegiance_init_r, state_r};
            `CMPP_OFF_REPORT: rd_nxt = {13'h0000,
                protection_types_field_o, selftest_time_o};
            default: rd_nxt = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_o <= 32'h00000000;
            pslverr_o <= 1'b0;
        end else if (psel_i && !pready_o) begin
            prdata_o <= rd_nxt;
            pslverr_o <= (paddr_i > `CMPP_OFF_SENSE) || (paddr_i[1:0] != 2'h0);
        end
    end

    // ---------------------------------------------------------------
    // queue error manager
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r <= cmpp_pkg::CMPP_RUN;
            allegiance_init_r <= 4'h0;
            hold_all_o <= 1'b0;
            abort_mask_o <= '0;
            ua_cleared_o <= '0;
        end else begin
            abort_mask_o <= '0;
            ua_cleared_o <= '0;
            case (state_r)
                cmpp_pkg::CMPP_RUN: begin
                    if (event_i.valid && event_i.check_cond) begin
                        allegiance_init_r <= event_i.initiator;
                        case (queue_error_policy)
                            `CMPP_QEP_BLOCK: begin
                                state_r <= cmpp_pkg::CMPP_HOLD;
                                hold_all_o <= 1'b1;
                            end
                            `CMPP_QEP_ABORT: begin
                                state_r <= cmpp_pkg::CMPP_ABORT;
                                abort_mask_o <= {NUM_INIT{1'b1}};
                                ua_cleared_o <= queued_i & ~own_bit;
                            end
                            `CMPP_QEP_OWN: begin
                                abort_mask_o <= own_bit & queued_i;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                cmpp_pkg::CMPP_HOLD: begin
                    if (event_i.valid && event_i.allegiance_clear) begin
                        state_r <= cmpp_pkg::CMPP_RUN;
                        hold_all_o <= 1'b0;
                    end
                end
                cmpp_pkg::CMPP_ABORT: begin
                    state_r <= cmpp_pkg::CMPP_RUN;
                end
                default: begin
                    state_r <= cmpp_pkg::CMPP_RUN;
                    hold_all_o <= 1'b0;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // sticky events: set wins over software clear
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            evt_r <= 4'h0;
            ua_blr_o <= 1'b0;
        end else begin
            ua_blr_o <= blr_change && pready_o;
            if (wr_en && pready_o && paddr_i == `CMPP_OFF_EVENT) begin
                evt_r <= evt_r & ~pwdata_i[3:0];
            end
            if (blr_change && pready_o) begin
                evt_r[0] <= 1'b1;
            end
            if (cmd_i.valid && cmd_reject_nxt()) begin
                evt_r[1] <= 1'b1;
            end
            if (|abort_mask_o) begin
                evt_r[2] <= 1'b1;
            end
            if (|ua_cleared_o) begin
                evt_r[3] <= 1'b1;
            end
        end
    end

    function automatic logic cmd_reject_nxt();
        return cmd_i.is_write && !cmd_i.has_prot
            && reject_unprotected_writes && formatted_prot_i;
    endfunction

    // ---------------------------------------------------------------
    // protection policy per command
    // ---------------------------------------------------------------
    assign prot_checked = !(zero_protect_check_skip && cmd_i.protect_zero);

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmd_reject_o <= 1'b0;
            cmd_accept_o <= 1'b0;
            check_skip_o <= 1'b0;
            tag_preserve_o <= 1'b0;
            tag_ignore_o <= 1'b0;
            tag_from_page_o <= 1'b0;
        end else begin
            cmd_reject_o <= cmd_i.valid && cmd_reject_nxt();
            cmd_accept_o <= cmd_i.valid && !cmd_reject_nxt();
            check_skip_o <= cmd_i.valid && !prot_checked;
            tag_preserve_o <= app_tag_owner;
            tag_ignore_o <= !app_tag_owner;
            tag_from_page_o <= cmd_i.valid && app_tag_page_enable
                && app_tag_owner && prot_checked
                && app_tag_check_support_i;
        end
    end

    // ---------------------------------------------------------------
    // reported fields
    // ---------------------------------------------------------------
    assign st_nxt = (selftest_seconds_i > 32'h0000ffff) ? `CMPP_ST_SAT
        : selftest_seconds_i[15:0];
    assign sense_cap = (max_sense_r == 8'h00 ||
        max_sense_r > SENSE_SUPPORTED) ? SENSE_SUPPORTED
        : max_sense_r;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            blr_page_o <= 1'b0;
            protection_types_field_o <= `CMPP_TYPES_NONE;
            selftest_time_o <= 16'h0000;
            sense_len_o <= 8'h00;
        end else begin
            blr_page_o <= block_length_report_enable;
            protection_types_field_o <= block_length_report_enable
                ? `CMPP_TYPES_REPORT : `CMPP_TYPES_NONE;
            selftest_time_o <= st_nxt;
            sense_len_o <= (sense_len_i > sense_cap) ? sense_cap
                : sense_len_i;
        end
    end
endmodule
`default_nettype wire

// ### cmpp_defs.svh
// register offsets, field positions, reset values and fixed codes
// assumes inclusion by bare name from the policy module and the top module
`ifndef CMPP_DEFS_SVH
`define CMPP_DEFS_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define CMPP_OFF_CTRL    12'h000
`define CMPP_OFF_PROT    12'h004
`define CMPP_OFF_EXT     12'h008
`define CMPP_OFF_EVENT   12'h00c
`define CMPP_OFF_STATUS  12'h010
`define CMPP_OFF_REPORT  12'h014
`define CMPP_OFF_SENSE   12'h018
// ---------------------------------------------------------------
// control word fields
// ---------------------------------------------------------------
`define CMPP_QEP_LSB     0
`define CMPP_OWNER_BIT   2
`define CMPP_PAGE_EN_BIT 3
`define CMPP_RUW_BIT     4
`define CMPP_BLR_BIT     5
`define CMPP_ZPCS_BIT    6
`define CMPP_BUSY_LSB    16
// ---------------------------------------------------------------
// policy codes and fixed values
// ---------------------------------------------------------------
`define CMPP_QEP_BLOCK   2'h0
`define CMPP_QEP_ABORT   2'h1
`define CMPP_QEP_RSVD    2'h2
`define CMPP_QEP_OWN     2'h3
`define CMPP_TYPES_REPORT 3'h6
`define CMPP_TYPES_NONE  3'h0
`define CMPP_ST_SAT      16'hffff
`define CMPP_PRIO_NONE   4'h0
`define CMPP_CTRL_RST    7'h00
`define CMPP_EXT_RST     8'h00
`endif

// ### cmpp_pkg.sv
// types shared by the control mode page policy block
// assumes cmpp_defs.svh sits in the include path
`default_nettype none
package cmpp_pkg;
    // ---------------------------------------------------------------
    // task status event from the command core
    // ---------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic       check_cond;
        logic       allegiance_clear;
        logic [3:0] initiator;
    } cmpp_event_s;
    // ---------------------------------------------------------------
    // per-command attributes
    // ---------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic has_prot;
        logic protect_zero;
        logic is_write;
    } cmpp_cmd_s;
    // ---------------------------------------------------------------
    // queue manager state
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        CMPP_RUN   = 2'b00,
        CMPP_HOLD  = 2'b01,
        CMPP_ABORT = 2'b11
    } cmpp_state_e;
endpackage
`default_nettype wire

// ### cmpp_policy_checker.sv
// assertions for the control mode page policy block
// assumes a bind onto cmpp_policy with one clock domain
`timescale 1ns/10ps
`default_nettype none
module cmpp_policy_checker #(
    parameter int NUM_INIT = 16,
    parameter logic [7:0] SENSE_SUPPORTED = 8'hfc
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // command core side
    input wire cmpp_pkg::cmpp_event_s event_i,
    input wire cmpp_pkg::cmpp_cmd_s cmd_i,
    input wire logic [NUM_INIT-1:0] queued_i,
    input wire logic formatted_prot_i,
    input wire logic app_tag_check_support_i,
    // policy outputs
    input wire logic hold_all_o,
    input wire logic [NUM_INIT-1:0] abort_mask_o,
    input wire logic [NUM_INIT-1:0] ua_cleared_o,
    input wire logic cmd_reject_o,
    input wire logic cmd_accept_o,
    input wire logic check_skip_o,
    input wire logic tag_preserve_o,
    input wire logic tag_from_page_o,
    input wire logic blr_page_o,
    input wire logic [2:0] protection_types_field_o,
    input wire logic [7:0] sense_len_o
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_fail;
        event_i.valid && event_i.check_cond;
    endsequence
    sequence s_clear;
        event_i.valid && event_i.allegiance_clear;
    endsequence
    a_types_follow: assert property (
        protection_types_field_o == (blr_page_o ? 3'h6 : 3'h0))
        else $error("types field disagrees with report flag");
    a_sense_cap: assert property (
        sense_len_o <= SENSE_SUPPORTED)
        else $error("sense length above supported maximum");
    a_prot_accept: assert property (
        cmd_i.valid && (cmd_i.has_prot || !cmd_i.is_write
        || !formatted_prot_i) |=> !cmd_reject_o)
        else $error("command rejected without cause");
    a_pulse_cause: assert property (
        (cmd_reject_o || cmd_accept_o || check_skip_o || tag_from_page_o)
        |-> $past(cmd_i.valid))
        else $error("command verdict without a command");
    a_page_source: assert property (
        tag_from_page_o |-> tag_preserve_o && !check_skip_o
        && $past(app_tag_check_support_i))
        else $error("tag taken from page without its conditions");
    a_abort_cause: assert property (
        (abort_mask_o != '0) |-> $past(event_i.valid && event_i.check_cond))
        else $error("abort without a failing status");
    a_ua_others: assert property (
        (ua_cleared_o != '0) |-> ((ua_cleared_o & ~$past(queued_i)) == '0)
        && !ua_cleared_o[$past(event_i.initiator)])
        else $error("attention to failing or idle initiator");
    // hold must not outlive the allegiance that caused it
    a_hold_release: assert property (
        hold_all_o ##0 s_clear |=> !hold_all_o)
        else $error("hold kept after allegiance cleared");
    c_fail_seen: cover property (s_fail);
endmodule
bind cmpp_policy cmpp_policy_checker #(.NUM_INIT(NUM_INIT),
    .SENSE_SUPPORTED(SENSE_SUPPORTED)) u_chk (.mclk_i, .arst_n_i,
    .event_i, .cmd_i, .queued_i, .formatted_prot_i,
    .app_tag_check_support_i, .hold_all_o, .abort_mask_o, .ua_cleared_o,
    .cmd_reject_o,
    .cmd_accept_o, .check_skip_o, .tag_preserve_o, .tag_from_page_o,
    .blr_page_o, .protection_types_field_o, .sense_len_o);
`default_nettype wire

// ### cmpp_core_model.sv
// command core model: status events, write commands and levels
// assumes the bench calls its tasks and sets levels on rising edges
`timescale 1ns/10ps
`default_nettype none
module cmpp_core_model (
    // clock
    input wire logic mclk_i,
    // towards the policy block
    output var cmpp_pkg::cmpp_event_s event_o,
    output var cmpp_pkg::cmpp_cmd_s cmd_o,
    output logic [15:0] queued_o,
    output logic fmt_o,
    output logic chk_o,
    output logic [31:0] sec_o,
    output logic [7:0] sense_o
);
    initial begin
        event_o = '0;
        cmd_o = '0;
        queued_o = 16'h0025;
        fmt_o = 1'b0;
        chk_o = 1'b0;
        sec_o = 32'h0;
        sense_o = 8'h0;
    end
    // fields flip once valid drops, so nothing leans on stale values
    task ev(input logic fail, input logic clr, input logic [3:0] who);
        @(posedge mclk_i);
        event_o <= '{1'b1, fail, clr, who};
        @(posedge mclk_i);
        event_o <= '{1'b0, ~fail, ~clr, ~who};
    endtask
    task cmd(input logic [2:0] f);
        @(posedge mclk_i);
        cmd_o <= {1'b1, f};
        @(posedge mclk_i);
        cmd_o <= {1'b0, ~f};
    endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the control mode page policy block
// assumes cmpp_core_model stands in for the command core
`timescale 1ns/10ps
`default_nettype none
`include "cmpp_defs.svh"
module tb_top;
    localparam logic [7:0] SUP = 8'hfc;
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    wire logic [31:0] prdata_o, selftest_seconds_i;
    wire logic pready_o, pslverr_o, hold_all_o, ua_blr_o, cmd_reject_o;
    wire logic cmd_accept_o, check_skip_o, tag_preserve_o, tag_ignore_o;
    wire logic tag_from_page_o, blr_page_o, formatted_prot_i;
    wire logic app_tag_check_support_i;
    wire logic [15:0] abort_mask_o, ua_cleared_o, queued_i, selftest_time_o;
    wire logic [7:0] sense_len_i, sense_len_o;
    wire logic [2:0] protection_types_field_o;
    wire cmpp_pkg::cmpp_event_s event_i;
    wire cmpp_pkg::cmpp_cmd_s cmd_i;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    int ua_seen = 0;
    logic [31:0] q;
    logic e;
    always #50 mclk_i = ~mclk_i;
    cmpp_policy #(.SENSE_SUPPORTED(SUP)) u_dut (.mclk_i, .arst_n_i, .psel_i,
        .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
        .pslverr_o, .event_i, .cmd_i, .queued_i, .formatted_prot_i,
        .app_tag_check_support_i, .selftest_seconds_i, .sense_len_i,
        .hold_all_o, .abort_mask_o, .ua_cleared_o, .ua_blr_o, .cmd_reject_o,
        .cmd_accept_o, .check_skip_o, .tag_preserve_o, .tag_ignore_o,
        .tag_from_page_o, .blr_page_o, .protection_types_field_o,
        .selftest_time_o, .sense_len_o);
    cmpp_core_model u_core (.mclk_i, .event_o(event_i), .cmd_o(cmd_i),
        .queued_o(queued_i), .fmt_o(formatted_prot_i),
        .chk_o(app_tag_check_support_i), .sec_o(selftest_seconds_i),
        .sense_o(sense_len_i));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task summarize;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checked++;
        if (s !== x) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask
    // no cycle count assumed: the timeout bounds the wait for pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do @(posedge mclk_i); while (pready_o !== 1'b1);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task settle;
        repeat (3) @(posedge mclk_i);
        #1;
    endtask
    always @(posedge mclk_i) begin
        if (ua_blr_o === 1'b1) ua_seen++;
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            summarize;
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_ext;
        apb(1'b0, `CMPP_OFF_EXT, 32'h0);
        chk("ext_b2", q[2], 1'b0);
        chk("ext_b1", q[1], 1'b1);
        chk("ext_b0", q[0], 1'b0);
        chk("ext_word", q, 32'h00000002);
        apb(1'b0, 12'h01c, 32'h0);
        chk("bad_err", e, 1'b1);
        chk("bad_data", q, 32'h0);
        apb(1'b0, 12'h006, 32'h0);
        chk("odd_err", e, 1'b1);
    endtask
    task t_queue;
        apb(1'b1, `CMPP_OFF_CTRL, 32'h0);
        u_core.ev(1'b1, 1'b0, 4'h2);
        #1;
        chk("hold_set", hold_all_o, 1'b1);
        chk("hold_abort", abort_mask_o, 16'h0);
        u_core.ev(1'b0, 1'b1, 4'h2);
        #1;
        chk("hold_clear", hold_all_o, 1'b0);
        apb(1'b1, `CMPP_OFF_CTRL, 32'h1);
        u_core.ev(1'b1, 1'b0, 4'h2);
        #1;
        chk("abort_all", abort_mask_o & 16'h0025, 16'h0025);
        chk("ua_others", ua_cleared_o, 16'h0025 & ~16'h0004);
        chk("abort_hold", hold_all_o, 1'b0);
        apb(1'b1, `CMPP_OFF_CTRL, 32'h3);
        u_core.ev(1'b1, 1'b0, 4'h2);
        #1;
        chk("abort_own", abort_mask_o, 16'h0004);
        chk("ua_none", ua_cleared_o, 16'h0);
        apb(1'b1, `CMPP_OFF_CTRL, 32'h2);
        u_core.ev(1'b1, 1'b0, 4'h2);
        #1;
        chk("rsvd_abort", abort_mask_o, 16'h0);
        apb(1'b0, `CMPP_OFF_STATUS, 32'h0);
        chk("rsvd_flag", q[6], 1'b1);
    endtask
    // entry nibbles: control byte, formatted, tag check, command, verdict
    task t_cmd;
        logic [23:0] t;
        logic [23:0] tv [8];
        tv = '{24'h001014, 24'h101018, 24'h100014, 24'h101054,
               24'h401036, 24'h0c1155, 24'h0c1054, 24'h4c1136};
        for (int i = 0; i < 8; i++) begin
            t = tv[i];
            apb(1'b1, `CMPP_OFF_CTRL, {24'h0, t[23:16]});
            @(posedge mclk_i);
            u_core.fmt_o <= t[12];
            u_core.chk_o <= t[8];
            u_core.cmd(t[6:4]);
            #1;
            chk("reject", cmd_reject_o, t[3]);
            chk("accept", cmd_accept_o, t[2]);
            chk("skip", check_skip_o, t[1]);
            chk("page", tag_from_page_o, t[0]);
            chk("tag_keep", tag_preserve_o, t[18]);
            chk("tag_free", tag_ignore_o, !t[18]);
        end
    endtask
    task t_blr;
        int n;
        apb(1'b1, `CMPP_OFF_CTRL, 32'hffffff80);
        settle;
        chk("busy_blr", blr_page_o, 1'b0);
        chk("busy_tag", tag_ignore_o, 1'b1);
        n = ua_seen;
        apb(1'b1, `CMPP_OFF_CTRL, 32'h20);
        settle;
        chk("blr_on", blr_page_o, 1'b1);
        chk("types_on", protection_types_field_o, 3'h6);
        apb(1'b1, `CMPP_OFF_CTRL, 32'h20);
        apb(1'b1, `CMPP_OFF_CTRL, 32'h0);
        settle;
        chk("types_off", protection_types_field_o, 3'h0);
        chk("ua_count", ua_seen - n, 2);
        apb(1'b0, `CMPP_OFF_EVENT, 32'h0);
        chk("evt_sticky", q, 32'h0000000f);
        apb(1'b1, `CMPP_OFF_EVENT, 32'h0000000f);
        apb(1'b0, `CMPP_OFF_EVENT, 32'h0);
        chk("evt_clear", q, 32'h00000000);
    endtask
    task t_levels;
        @(posedge mclk_i);
        u_core.sec_o <= 32'h00012345;
        settle;
        chk("st_sat", selftest_time_o, 16'hffff);
        @(posedge mclk_i);
        u_core.sec_o <= 32'h0000abcd;
        settle;
        chk("st_pass", selftest_time_o, 16'habcd);
        apb(1'b0, `CMPP_OFF_REPORT, 32'h0);
        chk("report", q, 32'h0000abcd);
        apb(1'b1, `CMPP_OFF_SENSE, 32'h0);
        @(posedge mclk_i);
        u_core.sense_o <= 8'hff;
        settle;
        chk("sense_sup", sense_len_o, SUP);
        @(posedge mclk_i);
        u_core.sense_o <= 8'h20;
        settle;
        chk("sense_in", sense_len_o, 8'h20);
        apb(1'b1, `CMPP_OFF_SENSE, 32'h10);
        settle;
        chk("sense_cfg", sense_len_o, 8'h10);
        @(posedge mclk_i);
        u_core.sense_o <= 8'h08;
        settle;
        chk("sense_min", sense_len_o, 8'h08);
    endtask
    initial begin
        repeat (8) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        t_ext;
        t_queue;
        t_cmd;
        t_blr;
        t_levels;
        summarize;
    end
endmodule
`default_nettype wire
